// File: rtcs_bus_if.sv
// two-wire bus between master and slave port, open-drain resolved here
`timescale 1ns/1ns
interface rtcs_bus_if;
  logic scl_o;
  logic scl_oe;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_s_o;
  logic sda_s_oe;
  wire scl = !(scl_oe && !scl_o);
  wire sda = !((sda_m_oe && !sda_m_o) || (sda_s_oe && !sda_s_o));
  modport slave (input scl, input sda, output sda_s_o, output sda_s_oe);
  modport master (input scl, input sda, output scl_o, output scl_oe, output sda_m_o, output sda_m_oe);
endinterface : rtcs_bus_if

// File: rtcs_checker.sv
// concurrent checks on the two-wire bus seen between master and slave port
`timescale 1ns/1ns
module rtcs_checker (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_s_o,
  input wire logic sda_s_oe,
  input wire logic address_strap_pin
);
  logic scl_q, sda_q, first, sel, rw;
  logic [3:0] nb;
  logic [7:0] sh;
  // bus events and the address decode of the shifted byte
  wire s_low = sda_s_oe && !sda_s_o;
  wire rise = scl && !scl_q;
  wire rise9 = rise && nb == 4'h8;
  wire start = scl && scl_q && sda_q && !sda;
  wire stop = scl && scl_q && !sda_q && sda;
  wire match = sh[7:1] == {rtcs_pkg::ADDR_FIXED, address_strap_pin};
  // bit counter, shifter and selection tracking
  always_ff @(posedge clk_sys)
  begin
    scl_q <= nrst ? scl : 1'b1;
    sda_q <= nrst ? sda : 1'b1;
    if (!nrst || start)
    begin
      nb <= 4'h0;
      first <= nrst;
    end
    else if (rise)
    begin
      nb <= rise9 ? 4'h0 : nb + 4'h1;
      if (!rise9) sh <= {sh[6:0], sda};
      if (rise9 && first) first <= 1'b0;
    end
    if (!nrst || stop) sel <= 1'b0;
    else if (rise9 && first)
    begin
      sel <= match;
      rw <= sh[0];
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);
  sequence ack_low_s;
    !sda [*6];
  endsequence
  slave_hold_high_a: assert property (scl && scl_q |-> $stable(s_low))
    else $error("slave sda moved while scl high");
  stop_release_a: assert property (stop |-> !s_low [*4])
    else $error("slave drives sda after stop");
  start_release_a: assert property (start |-> !s_low [*8])
    else $error("slave drives sda after start");
  addr_ack_a: assert property (rise9 && first && match |-> ack_low_s)
    else $error("own address not acknowledged");
  addr_ignore_a: assert property (rise9 && first && !match |-> sda)
    else $error("foreign address acknowledged");
  write_ack_a: assert property (rise9 && !first && sel && !rw |-> ack_low_s)
    else $error("written byte not acknowledged");
  nack_release_a: assert property (rise9 && !first && sel && rw && sda |=> !s_low [*8])
    else $error("slave drives sda after nack");
  unsel_quiet_a: assert property (!sel && !first |-> !s_low)
    else $error("unselected slave drives sda");
  open_drain_a: assert property (sda_s_oe |-> !sda_s_o)
    else $error("slave drives sda high");
  byte_frame_a: assert property (stop |-> nb == 4'h1)
    else $error("stop not after a whole byte and acknowledge");
endmodule : rtcs_checker

// File: rtcs_master.sv
// bus master end: generates start, address, bytes, acknowledge and stop
`timescale 1ns/1ns
module rtcs_master #(
  parameter int HALF_CYCLES = rtcs_pkg::SCL_HALF_CYCLES
) (
  input wire logic clk_sys,
  input wire logic nrst,
  rtcs_bus_if.master bus,
  input wire logic cmd_valid,
  input wire logic cmd_start,
  input wire logic cmd_stop,
  input wire logic cmd_read,
  input wire logic cmd_nack,
  input wire logic [7:0] cmd_data,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic rsp_ack
);
  initial
  begin
    if (HALF_CYCLES < 4 || HALF_CYCLES > 255)
      $error("rtcs_master: HALF_CYCLES must be 4..255");
  end

  typedef enum logic [5:0] {
    RTCM_IDLE = 6'b000001,
    RTCM_START = 6'b000010,
    RTCM_BITL = 6'b000100,
    RTCM_BITH = 6'b001000,
    RTCM_STOPL = 6'b010000,
    RTCM_STOPH = 6'b100000
  } rtcm_state_type;

  rtcm_state_type state;
  logic [7:0] tick_cnt;
  logic [7:0] shift;
  logic [3:0] bitcnt;
  logic rd, nack, stop_after, scl_low, sda_low, bus_held;
  logic sda_m, sda_s;

  // sda sampled through two flops
  always_ff @(posedge clk_sys)
  begin
    sda_m <= bus.sda;
    sda_s <= sda_m;
  end

  wire tick = tick_cnt == 8'(HALF_CYCLES - 1);
  wire ninth = bitcnt == 4'(rtcs_pkg::BYTE_BITS);
  wire drive_bit = rd ? (ninth ? nack : 1'b1) : (ninth ? 1'b1 : shift[7]);

  // half-period divider and bit sequencer
  always_ff @(posedge clk_sys)
  begin
    rsp_valid <= 1'b0;
    if (!nrst)
    begin
      state <= RTCM_IDLE;
      tick_cnt <= 8'h00;
      shift <= 8'h00;
      bitcnt <= 4'h0;
      rd <= 1'b0;
      nack <= 1'b0;
      stop_after <= 1'b0;
      scl_low <= 1'b0;
      sda_low <= 1'b0;
      bus_held <= 1'b0;
      cmd_ready <= 1'b0;
      rsp_data <= 8'h00;
      rsp_ack <= 1'b0;
    end
    else
    begin
      tick_cnt <= (tick || state == RTCM_IDLE) ? 8'h00 : tick_cnt + 8'h01;
      case (state)
        RTCM_IDLE:
        begin
          cmd_ready <= 1'b1;
          if (cmd_valid && cmd_ready && (bus_held || cmd_start))
          begin
            cmd_ready <= 1'b0;
            shift <= cmd_data;
            rd <= cmd_read;
            nack <= cmd_nack;
            stop_after <= cmd_stop;
            bitcnt <= 4'h0;
            if (cmd_start)
            begin
              sda_low <= 1'b0; // data released first so a repeated start sees a falling edge
              state <= RTCM_START;
            end
            else
              state <= RTCM_BITL;
          end
        end
        // start: release clock if held, pull data with clock high, then pull clock
        RTCM_START:
          if (tick && scl_low && !sda_low)
            scl_low <= 1'b0;
          else if (tick && !sda_low)
            sda_low <= 1'b1;
          else if (tick)
          begin
            scl_low <= 1'b1;
            bus_held <= 1'b1;
            state <= RTCM_BITL;
          end
        RTCM_BITL:
          if (tick)
          begin
            sda_low <= !drive_bit;
            state <= RTCM_BITH;
          end
          else if (tick_cnt == 8'h00)
            scl_low <= 1'b1;
        RTCM_BITH:
          if (tick)
          begin
            scl_low <= 1'b1;
            if (ninth)
            begin
              rsp_ack <= !sda_s;
              rsp_data <= shift;
              rsp_valid <= 1'b1;
              if (stop_after)
                state <= RTCM_STOPL;
              else
                state <= RTCM_IDLE;
            end
            else
            begin
              shift <= {shift[6:0], sda_s};
              bitcnt <= bitcnt + 4'h1;
              state <= RTCM_BITL;
            end
          end
          else if (tick_cnt == 8'h00)
            scl_low <= 1'b0;
        RTCM_STOPL:
          if (tick)
          begin
            scl_low <= 1'b0;
            state <= RTCM_STOPH;
          end
          else
            sda_low <= 1'b1;
        RTCM_STOPH:
          if (tick)
          begin
            sda_low <= 1'b0;
            bus_held <= 1'b0;
            state <= RTCM_IDLE;
          end
        default:
          state <= RTCM_IDLE;
      endcase
    end
  end

  assign bus.scl_o = 1'b0;
  assign bus.scl_oe = scl_low;
  assign bus.sda_m_o = 1'b0;
  assign bus.sda_m_oe = sda_low;
endmodule : rtcs_master

// File: rtcs_pkg.sv
// shared constants for the two-wire slave port and its bus master
package rtcs_pkg;
  localparam logic [5:0] ADDR_FIXED = 6'h28; // address bits 7..2 = 101000
  localparam int BYTE_BITS = 8;
  localparam int PTR_RESET = 0;
  localparam int MEM_WORDS = 256;
  localparam int SCL_HALF_CYCLES = 6; // master scl half period in clk_sys cycles
endpackage : rtcs_pkg

// File: rtcs_slave.sv
// slave port of the clock/calendar chip: address match, byte receive and send, word pointer and ram
`timescale 1ns/1ns
// Overview of operation
// - one bit per scl pulse, data stable high
// - idle when both high; release sda otherwise
// - sda fall with scl high restarts addressing
// - sda rise with scl high returns idle
// - master starts only on idle bus
// - eight bits then one acknowledge, unlimited bytes
// - acknowledge every received byte incl address
// - master acknowledges read bytes except last
// - acknowledger holds sda low whole ack high
// - master ends read with missing acknowledge
// - after nack slave releases sda high
// - first byte is address; ignore on mismatch
// - slave only; scl input; sda open drain
// - match 101000, strap bit, then read bit
// - strap pin selects one of two addresses
module rtcs_slave #(
  parameter int MEM_WORDS = rtcs_pkg::MEM_WORDS
) (
  input wire logic clk_sys,
  input wire logic nrst,
  rtcs_bus_if.slave bus,
  input wire logic address_strap_pin,
  output logic busy,
  output logic [7:0] word_ptr,
  output logic wr_strobe,
  output logic [7:0] wr_data
);
  initial
  begin
    if (MEM_WORDS < 1 || MEM_WORDS > 256)
      $error("rtcs_slave: MEM_WORDS must be 1..256");
  end

  typedef enum logic [4:0] {
    RTCS_IDLE = 5'b00001,
    RTCS_RECV = 5'b00010,
    RTCS_ACK = 5'b00100,
    RTCS_SEND = 5'b01000,
    RTCS_RACK = 5'b10000
  } rtcs_state_type;

  rtcs_state_type state;
  logic [7:0] mem [0:MEM_WORDS-1];
  logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
  logic strap_m, strap_s;
  logic [7:0] shift;
  logic [3:0] bitcnt;
  logic first_byte, ptr_byte, reading, addressed;
  logic sda_low;

  // two-flop synchronisers for pins
  always_ff @(posedge clk_sys)
  begin
    scl_m <= bus.scl;
    scl_s <= scl_m;
    sda_m <= bus.sda;
    sda_s <= sda_m;
    strap_m <= address_strap_pin;
    strap_s <= strap_m;
    scl_d <= scl_s;
    sda_d <= sda_s;
  end

  // bus event decode
  wire scl_rise = scl_s && !scl_d;
  wire scl_fall = !scl_s && scl_d;
  wire start_det = scl_s && scl_d && sda_d && !sda_s;
  wire stop_det = scl_s && scl_d && !sda_d && sda_s;
  wire [7:0] rx_byte = {shift[6:0], sda_s};
  // address match on the completed first byte, checked at the scl fall after the eighth rise
  wire addr_hit = shift[7:2] == rtcs_pkg::ADDR_FIXED && shift[1] == strap_s;
  wire [7:0] rd_byte = mem[word_ptr];

  // slave sequencer, actions on scl edges and on start/stop; scl only sampled
  always_ff @(posedge clk_sys)
  begin
    wr_strobe <= 1'b0;
    if (!nrst)
    begin
      state <= RTCS_IDLE;
      shift <= 8'h00;
      bitcnt <= 4'h0;
      first_byte <= 1'b0;
      ptr_byte <= 1'b0;
      reading <= 1'b0;
      addressed <= 1'b0;
      sda_low <= 1'b0;
      busy <= 1'b0;
      word_ptr <= 8'(rtcs_pkg::PTR_RESET);
      wr_data <= 8'h00;
    end
    else if (start_det)
    begin
      state <= RTCS_RECV;
      bitcnt <= 4'h0;
      first_byte <= 1'b1;
      addressed <= 1'b0;
      sda_low <= 1'b0;
      busy <= 1'b1;
    end
    else if (stop_det)
    begin
      state <= RTCS_IDLE;
      sda_low <= 1'b0;
      busy <= 1'b0;
    end
    else
    begin
      case (state)
        RTCS_IDLE:
        begin
          sda_low <= 1'b0;
        end
        RTCS_RECV:
        begin
          if (scl_rise)
          begin
            shift <= rx_byte;
            bitcnt <= bitcnt + 4'h1;
          end
          else if (scl_fall && bitcnt == 4'(rtcs_pkg::BYTE_BITS))
          begin
            bitcnt <= 4'h0;
            if (first_byte)
            begin
              first_byte <= 1'b0;
              if (addr_hit)
              begin
                addressed <= 1'b1;
                reading <= shift[0];
                ptr_byte <= !shift[0];
                sda_low <= 1'b1;
                state <= RTCS_ACK;
              end
              else
                state <= RTCS_IDLE;
            end
            else
            begin
              if (ptr_byte)
                word_ptr <= shift;
              else
              begin
                wr_strobe <= 1'b1;
                wr_data <= shift;
                word_ptr <= word_ptr + 8'h01;
              end
              ptr_byte <= 1'b0;
              sda_low <= 1'b1;
              state <= RTCS_ACK;
            end
          end
        end
        RTCS_ACK:
        begin
          if (scl_fall) // low held through the ninth high phase
          begin
            if (reading)
            begin
              shift <= rd_byte;
              sda_low <= !rd_byte[7];
              bitcnt <= 4'h1;
              state <= RTCS_SEND;
            end
            else
            begin
              sda_low <= 1'b0;
              state <= RTCS_RECV;
            end
          end
        end
        RTCS_SEND:
        begin
          if (scl_fall)
          begin
            if (bitcnt == 4'(rtcs_pkg::BYTE_BITS))
            begin
              sda_low <= 1'b0; // release for master ack
              bitcnt <= 4'h0;
              word_ptr <= word_ptr + 8'h01;
              state <= RTCS_RACK;
            end
            else
            begin
              sda_low <= !shift[6];
              shift <= {shift[6:0], 1'b0};
              bitcnt <= bitcnt + 4'h1;
            end
          end
        end
        RTCS_RACK:
        begin
          if (scl_rise && sda_s)
            state <= RTCS_IDLE;
          else if (scl_rise)
            reading <= 1'b1;
          else if (scl_fall)
          begin
            shift <= rd_byte;
            sda_low <= !rd_byte[7];
            bitcnt <= 4'h1;
            state <= RTCS_SEND;
          end
        end
        default:
          state <= RTCS_IDLE;
      endcase
    end
  end

  // ram written by received data bytes
  always_ff @(posedge clk_sys)
  begin
    if (wr_strobe)
      mem[word_ptr - 8'h01] <= wr_data;
  end

  // open drain drive, only ever pulls low
  assign bus.sda_s_o = 1'b0;
  assign bus.sda_s_oe = sda_low && addressed;
endmodule : rtcs_slave

// File: testbench.sv
// self-checking bench: master and slave port joined over the two-wire bus
`timescale 1ns/1ns
module testbench;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic address_strap_pin = 1'b0;
  logic cmd_valid = 1'b0, cmd_start = 1'b0, cmd_stop = 1'b0, cmd_read = 1'b0, cmd_nack = 1'b0;
  logic [7:0] cmd_data = 8'h00;
  logic cmd_ready, rsp_valid, rsp_ack, busy, wr_strobe;
  logic [7:0] rsp_data, word_ptr, wr_data;
  logic [7:0] mem [256];
  integer seed = 32'h59f1_951b;
  int err_total = 0;
  int checks_done = 0;
  int wcnt = 0;
  // clock and count of write strobes
  always #2 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (wr_strobe === 1'b1) wcnt++;
  rtcs_bus_if rtcs_bus_if_i ();
  rtcs_master rtcs_master_i (.clk_sys(clk_sys), .nrst(nrst), .bus(rtcs_bus_if_i), .cmd_valid(cmd_valid),
    .cmd_start(cmd_start), .cmd_stop(cmd_stop), .cmd_read(cmd_read), .cmd_nack(cmd_nack), .cmd_data(cmd_data),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_ack(rsp_ack));
  rtcs_slave rtcs_slave_i (.clk_sys(clk_sys), .nrst(nrst), .bus(rtcs_bus_if_i),
    .address_strap_pin(address_strap_pin), .busy(busy), .word_ptr(word_ptr), .wr_strobe(wr_strobe),
    .wr_data(wr_data));
  rtcs_checker rtcs_checker_i (.clk_sys(clk_sys), .nrst(nrst), .scl(rtcs_bus_if_i.scl), .sda(rtcs_bus_if_i.sda),
    .sda_s_o(rtcs_bus_if_i.sda_s_o), .sda_s_oe(rtcs_bus_if_i.sda_s_oe), .address_strap_pin(address_strap_pin));
  // expected address byte for a strap level and direction
  function automatic logic [7:0] addr_byte(input logic lvl, input logic rd);
    return {rtcs_pkg::ADDR_FIXED, lvl, rd};
  endfunction : addr_byte
  task summarize;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : summarize
  task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // bounded wait: 0 ready, 1 response, 2 slave idle
  task wait_hi(input int which);
    int n;
    n = 0;
    @(posedge clk_sys);
    while ((which == 0 ? cmd_ready : which == 1 ? rsp_valid : !busy) !== 1'b1)
    begin
      n++;
      if (n > 4000)
      begin
        chk("wait", 8'h01, 8'h00);
        summarize;
      end
      @(posedge clk_sys);
    end
  endtask : wait_hi
  // one byte through the master, held until taken
  task xfer(input logic st, input logic sp, input logic rd, input logic nk, input logic [7:0] d);
    #1 {cmd_valid, cmd_start, cmd_stop, cmd_read, cmd_nack, cmd_data} = {1'b1, st, sp, rd, nk, d};
    wait_hi(0);
    #1 cmd_valid = 1'b0;
    wait_hi(1);
  endtask : xfer
  // write, read back through repeated start, foreign addresses, for both strap levels
  initial
  begin : main
    int n;
    int wexp;
    logic [7:0] p, d;
    logic s;
    wexp = 0;
    repeat (5) @(posedge clk_sys);
    #1 nrst = 1'b1;
    @(posedge clk_sys);
    chk("ptr rst", 8'(rtcs_pkg::PTR_RESET), word_ptr);
    chk("busy rst", 8'h00, {7'h00, busy});
    for (int k = 0; k < 2; k++)
    begin
      s = k[0];
      @(posedge clk_sys);
      #1 address_strap_pin = s;
      repeat (4) @(posedge clk_sys);
      p = 8'($random(seed));
      n = 2 + k;
      xfer(1'b1, 1'b0, 1'b0, 1'b0, addr_byte(s, 1'b0));
      chk("addr ack", 8'h01, {7'h00, rsp_ack});
      xfer(1'b0, 1'b0, 1'b0, 1'b0, p);
      chk("ptr", p, word_ptr);
      for (int j = 0; j < n; j++)
      begin
        d = 8'($random(seed));
        mem[8'(p + j)] = d;
        xfer(1'b0, j == n - 1, 1'b0, 1'b0, d);
        chk("data ack", 8'h01, {7'h00, rsp_ack});
        chk("wr data", d, wr_data);
        chk("ptr inc", 8'(p + j + 1), word_ptr);
      end
      wexp += n;
      wait_hi(2);
      chk("busy", 8'h00, {7'h00, busy});
      chk("strobes", 8'(wexp), 8'(wcnt));
      xfer(1'b1, 1'b0, 1'b0, 1'b0, addr_byte(s, 1'b0));
      xfer(1'b0, 1'b0, 1'b0, 1'b0, p);
      xfer(1'b1, 1'b0, 1'b0, 1'b0, addr_byte(s, 1'b1));
      chk("rd addr ack", 8'h01, {7'h00, rsp_ack});
      for (int j = 0; j < n; j++)
      begin
        xfer(1'b0, j == n - 1, 1'b1, j == n - 1, 8'h00);
        chk("rd data", mem[8'(p + j)], rsp_data);
      end
      chk("rd ptr", 8'(p + n), word_ptr);
      for (int a = 0; a < 2; a++)
      begin
        xfer(1'b1, 1'b0, 1'b0, 1'b0, a == 0 ? addr_byte(!s, 1'b0) : addr_byte(s, 1'b0) ^ 8'h80);
        chk("foreign ack", 8'h00, {7'h00, rsp_ack});
        xfer(1'b0, 1'b1, 1'b0, 1'b0, 8'h5a);
        chk("ignored ack", 8'h00, {7'h00, rsp_ack});
      end
      chk("no strobe", 8'(wexp), 8'(wcnt));
    end
    summarize;
  end
endmodule : testbench
